// ==== shared/rx_err_regs.vh ====
// Register offsets, field positions and reset values of the receive link error monitor.
// Included by the monitor top; holds definitions only.
`ifndef RX_ERR_REGS_VH
`define RX_ERR_REGS_VH

`define ERR_STATUS_OFS     12'h060
`define ERR_ENABLE_OFS     12'h064
`define ERR_CLEAR_OFS      12'h068
`define ERR_CTRL_OFS       12'h06C

`define BIT_SYSREF_LEMC    0
`define BIT_DLL_READY      1
`define BIT_FRAME_READY    2
`define BIT_CMD_READY      3
`define BIT_CDR_LOCK       4
`define BIT_PCFIFO_EMPTY   5
`define BIT_PCFIFO_FULL    6
`define BIT_LANE_DESKEW    7
`define BIT_SYNC_HEADER    8
`define BIT_EOMB           9
`define BIT_ECC_CORR       10
`define TX_ERR_LSB         16
`define TX_ERR_W           8

`define ERR_USED_MASK      32'h00FF07FF
`define ERR_STATUS_RST     32'h00000000
`define ERR_ENABLE_RST     32'h00FF03FF

`define CTRL_AUTO_REINIT   0
`define CTRL_PERIOD_LSB    8
`define CTRL_COUNT_LSB     24
`define CTRL_AUTO_RST      1'b1
`define LEMC_PERIOD_M1_RST 8'h1F
`define SYSREF_BAD_LIMIT   2

`define SH_BAD_ZERO        2'h0
`define SH_BAD_ONE         2'h3
`define EOMB_PILOT         5'h01

`endif

// ==== src/bit_sync.v ====
// Two-flop synchroniser for a vector of independent level signals.
// Each bit is assumed to change slowly against pclk; no bus coherency is promised.
`timescale 1ns/100ps
`default_nettype none

module bit_sync #(
  parameter WIDTH = 1
) (
  input  wire             pclk,     // System clock.
  input  wire             presetn,  // Asynchronous reset, active low.
  input  wire             ce,       // Clock enable.
  input  wire [WIDTH-1:0] d_async,  // Level from another domain.
  output wire [WIDTH-1:0] q_sync    // Synchronised level.
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // The first stage feeds only the second stage.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else if (ce) begin
      meta_ff <= d_async;
      sync_ff <= meta_ff;
    end
  end

  assign q_sync = sync_ff;

endmodule

`default_nettype wire

// ==== src/lemc_sysref_check.v ====
// Local extended multiblock counter and SYSREF alignment checker.
// Expects a one-cycle SYSREF rising-edge pulse already in the pclk domain.
`timescale 1ns/100ps
`default_nettype none

module lemc_sysref_check #(
  parameter BAD_LIMIT = 2
) (
  input  wire       pclk,          // System clock.
  input  wire       presetn,       // Asynchronous reset, active low.
  input  wire       ce,            // Clock enable.
  input  wire       sysref_rise,   // SYSREF edge pulse.
  input  wire [7:0] period_m1,     // Counter period minus one.
  output wire [7:0] lemc_count,    // Current counter value.
  output reg        misalign_err   // Pulse on repeated misaligned SYSREF.
);

  reg  [7:0] count_ff;
  reg  [7:0] bad_cnt_ff;
  wire       boundary;
  wire       misaligned;

  assign boundary   = (count_ff == period_m1);
  assign misaligned = sysref_rise && !boundary;

  // SYSREF always restarts the counter; only a restart off the boundary shifts the phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 8'h00;
    end else if (ce) begin
      if (sysref_rise || boundary) begin
        count_ff <= 8'h00;
      end else begin
        count_ff <= count_ff + 8'h01;
      end
    end
  end

  // A single stray edge is tolerated; a run of them means SYSREF keeps moving the counter.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_cnt_ff   <= 8'h00;
      misalign_err <= 1'b0;
    end else if (ce) begin
      misalign_err <= misaligned && (bad_cnt_ff >= BAD_LIMIT - 1);
      if (sysref_rise && boundary) begin
        bad_cnt_ff <= 8'h00;
      end else if (misaligned && bad_cnt_ff != 8'hFF) begin
        bad_cnt_ff <= bad_cnt_ff + 8'h01;
      end
    end
  end

  assign lemc_count = count_ff;

endmodule

`default_nettype wire

// ==== src/rx_link_error_monitor.v ====
// Receive link error monitor: detects link errors, keeps sticky status, raises one interrupt.
// Assumes an APB master on pclk; stream handshakes are on pclk, lane and SYSREF levels are not.
`timescale 1ns/100ps
`default_nettype none
`include "rx_err_regs.vh"

module rx_link_error_monitor #(
  parameter LANES     = 4,
  parameter ADDR_W    = 12,
  parameter BAD_LIMIT = `SYSREF_BAD_LIMIT
) (
  input  wire              pclk,             // System and link clock, 40 MHz.
  input  wire              presetn,          // Asynchronous reset, active low.
  input  wire              ce,               // Clock enable; low freezes all state.
  input  wire              psel,             // APB select.
  input  wire              penable,          // APB access phase.
  input  wire              pwrite,           // APB direction, high for write.
  input  wire [ADDR_W-1:0] paddr,            // APB byte address.
  input  wire [31:0]       pwdata,           // APB write data.
  input  wire [3:0]        pstrb,            // APB write byte strobes.
  output wire              pready,           // APB ready.
  output wire              pslverr,          // APB error on unmapped address.
  output reg  [31:0]       prdata,           // APB read data.
  input  wire              sysref,           // SYSREF pin, asynchronous.
  input  wire              dll_valid,        // Base-core stream data offered.
  input  wire              dll_ready,        // Base-core consumer ready.
  input  wire              frame_valid,      // Transport stream data offered.
  input  wire              frame_ready,      // Transport consumer ready.
  input  wire              cmd_valid,        // Command stream data offered.
  input  wire              cmd_ready,        // Command consumer ready.
  input  wire              cdr_locked,       // Recovered-clock lock, asynchronous.
  input  wire [LANES-1:0]  pcfifo_empty,     // Per-lane FIFO empty, asynchronous.
  input  wire [LANES-1:0]  pcfifo_full,      // Per-lane FIFO full, asynchronous.
  input  wire              deskew_fail,      // Lane deskew failure pulse.
  input  wire              sh_strobe,        // Sync header position strobe.
  input  wire [1:0]        sh_bits,          // Sync header bits.
  input  wire              eomb_strobe,      // End-of-multiblock position strobe.
  input  wire [4:0]        eomb_pilot,       // Pilot field at that position.
  input  wire              ecc_corrected,    // Correctable ECC event pulse.
  input  wire [7:0]        tx_err_evt,       // Transmit side error pulses.
  output reg               link_reinit,      // Link reinit request pulse.
  output reg               irq               // Level interrupt, active high.
);

  localparam SYNC_W = 2 + 2 * LANES;

  localparam SEL_NONE = 3'd0;
  localparam SEL_STAT = 3'd1;
  localparam SEL_EN   = 3'd2;
  localparam SEL_CLR  = 3'd3;
  localparam SEL_CTRL = 3'd4;

  reg  [31:0]       status_ff;
  reg  [31:0]       enable_ff;
  reg               auto_reinit_ff;
  reg  [7:0]        period_m1_ff;
  reg               sysref_d_ff;
  reg               cdr_d_ff;
  reg  [31:0]       nxt_status;
  reg  [31:0]       nxt_enable;
  reg  [31:0]       nxt_ctrl;
  reg  [31:0]       nxt_prdata;
  reg  [31:0]       clr_mask;
  reg  [31:0]       evt;
  wire [SYNC_W-1:0] sync_q;
  wire              sysref_s;
  wire              cdr_s;
  wire [LANES-1:0]  empty_s;
  wire [LANES-1:0]  full_s;
  wire              sysref_rise;
  wire              lemc_err;
  wire [7:0]        lemc_count;
  wire [31:0]       wmask;
  wire [31:0]       ctrl_rd;
  wire [2:0]        wr_sel;
  wire [2:0]        rd_sel;
  wire              wr_en;
  wire              rd_load;
  reg               rd_valid_ff;
  genvar            g;

  // Address decode shared by the read and write paths.
  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    begin
      if (addr == `ERR_STATUS_OFS) begin
        reg_sel = SEL_STAT;
      end else if (addr == `ERR_ENABLE_OFS) begin
        reg_sel = SEL_EN;
      end else if (addr == `ERR_CLEAR_OFS) begin
        reg_sel = SEL_CLR;
      end else if (addr == `ERR_CTRL_OFS) begin
        reg_sel = SEL_CTRL;
      end else begin
        reg_sel = SEL_NONE;
      end
    end
  endfunction

  bit_sync #(
    .WIDTH   (SYNC_W)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d_async ({pcfifo_full, pcfifo_empty, cdr_locked, sysref}),
    .q_sync  (sync_q)
  );

  assign sysref_s = sync_q[0];
  assign cdr_s    = sync_q[1];
  assign empty_s  = sync_q[2 +: LANES];
  assign full_s   = sync_q[2 + LANES +: LANES];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_d_ff <= 1'b0;
      cdr_d_ff    <= 1'b0;
    end else if (ce) begin
      sysref_d_ff <= sysref_s;
      cdr_d_ff    <= cdr_s;
    end
  end

  assign sysref_rise = sysref_s && !sysref_d_ff;

  lemc_sysref_check #(
    .BAD_LIMIT    (BAD_LIMIT)
  ) u_lemc (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .sysref_rise  (sysref_rise),
    .period_m1    (period_m1_ff),
    .lemc_count   (lemc_count),
    .misalign_err (lemc_err)
  );

  // Error events, one bit per status position.
  always @* begin
    evt                    = 32'h00000000;
    evt[`BIT_SYSREF_LEMC]  = lemc_err;
    evt[`BIT_DLL_READY]    = dll_valid && !dll_ready;
    evt[`BIT_FRAME_READY]  = frame_valid && !frame_ready;
    evt[`BIT_CMD_READY]    = cmd_valid && !cmd_ready;
    evt[`BIT_CDR_LOCK]     = cdr_d_ff && !cdr_s;
    evt[`BIT_PCFIFO_EMPTY] = |empty_s;
    evt[`BIT_PCFIFO_FULL]  = |full_s;
    evt[`BIT_LANE_DESKEW]  = deskew_fail;
    evt[`BIT_SYNC_HEADER]  = sh_strobe && (sh_bits == `SH_BAD_ZERO ||
                                           sh_bits == `SH_BAD_ONE);
    evt[`BIT_EOMB]         = eomb_strobe && (eomb_pilot != `EOMB_PILOT);
    evt[`BIT_ECC_CORR]     = ecc_corrected;
    evt[`TX_ERR_LSB +: `TX_ERR_W] = tx_err_evt;
  end

  // A frozen block completes no transfer, and a read waits until its data has been loaded at an
  // enabled edge, so a setup cycle lost to a low clock enable costs a wait state, not stale data.
  assign pready  = ce && (pwrite || !penable || rd_valid_ff);
  assign rd_load = psel && !pwrite && !rd_valid_ff;
  assign wr_sel  = reg_sel(paddr);
  assign rd_sel  = reg_sel(paddr);
  assign wr_en   = psel && penable && pwrite && ce;
  assign pslverr = psel && penable && (rd_sel == SEL_NONE);

  // Each byte strobe widens to the eight bits of its lane.
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_wmask
      assign wmask[8*g +: 8] = {8{pstrb[g]}};
    end
  endgenerate

  assign ctrl_rd = {lemc_count, 8'h00, period_m1_ff, 7'h00, auto_reinit_ff};

  // Clears come through the status word itself or the separate clear word.
  always @* begin
    clr_mask = 32'h00000000;
    if (wr_en && (wr_sel == SEL_STAT || wr_sel == SEL_CLR)) begin
      clr_mask = pwdata & wmask;
    end
  end

  // A clear and a new event in the same cycle leave the bit set so no error is lost.
  always @* begin
    nxt_status = ((status_ff & ~clr_mask) | evt) & `ERR_USED_MASK;
  end

  always @* begin
    nxt_enable = enable_ff;
    if (wr_en && wr_sel == SEL_EN) begin
      nxt_enable = ((enable_ff & ~wmask) | (pwdata & wmask)) & `ERR_USED_MASK;
    end
  end

  always @* begin
    nxt_ctrl = {16'h0000, period_m1_ff, 7'h00, auto_reinit_ff};
    if (wr_en && wr_sel == SEL_CTRL) begin
      nxt_ctrl = (nxt_ctrl & ~wmask) | (pwdata & wmask);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= `ERR_STATUS_RST;
      enable_ff <= `ERR_ENABLE_RST;
    end else if (ce) begin
      status_ff <= nxt_status;
      enable_ff <= nxt_enable;
    end
  end

  // Control fields: automatic reinit and the multiblock counter period.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_reinit_ff <= `CTRL_AUTO_RST;
      period_m1_ff   <= `LEMC_PERIOD_M1_RST;
    end else if (ce) begin
      auto_reinit_ff <= nxt_ctrl[`CTRL_AUTO_REINIT];
      period_m1_ff   <= nxt_ctrl[`CTRL_PERIOD_LSB +: 8];
    end
  end

  // Read data is captured once per read, normally in the setup cycle, and held through the access phase.
  always @* begin
    if (rd_sel == SEL_STAT) begin
      nxt_prdata = status_ff;
    end else if (rd_sel == SEL_EN) begin
      nxt_prdata = enable_ff;
    end else if (rd_sel == SEL_CTRL) begin
      nxt_prdata = ctrl_rd;
    end else begin
      nxt_prdata = 32'h00000000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= 32'h00000000;
      rd_valid_ff <= 1'b0;
    end else if (ce) begin
      if (rd_load) begin
        prdata      <= nxt_prdata;
        rd_valid_ff <= 1'b1;
      end else if (!psel || penable) begin
        rd_valid_ff <= 1'b0;
      end
    end
  end

  // Reinit follows the moment the SYSREF bit becomes set, not its continued presence.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_reinit <= 1'b0;
    end else if (ce) begin
      link_reinit <= auto_reinit_ff && nxt_status[`BIT_SYSREF_LEMC] &&
                     !status_ff[`BIT_SYSREF_LEMC];
    end
  end

  // Next-state status and enable let the interrupt rise at the same edge as its cause.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(nxt_status & nxt_enable);
    end
  end

endmodule

`default_nettype wire

// ==== verif/rx_err_checker.sv ====
// Checker of the monitor top: error inputs against the interrupt, reinit pulse and bus error.
// Assumes it is bound to the monitor top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module rx_err_checker #(
  parameter LANES = 4
) (
  input wire logic             pclk,         // Clock.
  input wire logic             presetn,      // Reset.
  input wire logic             ce,           // Enable.
  input wire logic             psel,         // Select.
  input wire logic             penable,      // Access.
  input wire logic             pwrite,       // Write.
  input wire logic [11:0]      paddr,        // Address.
  input wire logic [31:0]      pwdata,       // Data.
  input wire logic [3:0]       pstrb,        // Strobes.
  input wire logic             pslverr,      // Bus error.
  input wire logic             dll_valid,    // Offered.
  input wire logic             dll_ready,    // Ready.
  input wire logic             deskew_fail,  // Deskew.
  input wire logic             sh_strobe,    // Header.
  input wire logic [1:0]       sh_bits,      // Bits.
  input wire logic             eomb_strobe,  // Pilot.
  input wire logic [4:0]       eomb_pilot,   // Field.
  input wire logic [LANES-1:0] pcfifo_empty, // Empty.
  input wire logic [LANES-1:0] pcfifo_full,  // Full.
  input wire logic             link_reinit,  // Reinit.
  input wire logic             irq           // Interrupt.
);
  logic [31:0] en_ff;
  logic        wr;
  assign wr = psel && penable && pwrite && ce;
  // A shadow of the enable register tells each event and reinit check whether its bit may raise the interrupt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= 32'h00FF03FF;
    end else if (wr && paddr == 12'h064) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          en_ff[8*i +: 8] <= pwdata[8*i +: 8];
        end
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ev(c, e);
    ce && !wr && c && e |=> irq;
  endproperty
  a_dll_ready_irq: assert property (p_ev(dll_valid && !dll_ready, en_ff[1])) else $error("dll irq");
  a_deskew_irq: assert property (p_ev(deskew_fail, en_ff[7])) else $error("deskew irq");
  a_sync_header_irq: assert property (p_ev(sh_strobe && sh_bits[0] == sh_bits[1], en_ff[8])) else $error("sh");
  a_pilot_irq: assert property (p_ev(eomb_strobe && eomb_pilot != 5'h01, en_ff[9])) else $error("pilot");
  a_empty_irq: assert property ((ce && !wr && |pcfifo_empty && en_ff[5]) [*3] |=> irq) else $error("empty");
  a_full_irq: assert property ((ce && !wr && |pcfifo_full && en_ff[6]) [*3] |=> irq) else $error("full");
  a_irq_sticky: assert property (irq && !wr |=> irq) else $error("irq dropped");
  a_reinit_pulse: assert property (link_reinit |-> (irq || !en_ff[0]) ##1 !link_reinit) else $error("reinit");
  a_slverr_map: assert property (psel && penable |-> pslverr == !(paddr inside {12'h060, 12'h064, 12'h068,
    12'h06C})) else $error("slverr");
  cover property (link_reinit);
  cover property (irq ##1 !irq);
  cover property (pslverr);
endmodule
bind rx_link_error_monitor rx_err_checker #(.LANES(LANES)) rx_err_checker_inst (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .dll_valid(dll_valid), .dll_ready(dll_ready), .deskew_fail(deskew_fail),
  .sh_strobe(sh_strobe), .sh_bits(sh_bits), .eomb_strobe(eomb_strobe), .eomb_pilot(eomb_pilot),
  .pcfifo_empty(pcfifo_empty), .pcfifo_full(pcfifo_full), .link_reinit(link_reinit), .irq(irq));
`default_nettype wire

// ==== verif/conv_tx_model.sv ====
// Far-side converter model: SYSREF, lock, lane FIFO flags and sync word fields.
// Assumes one-cycle go requests from the bench, issued only while busy is low.
`timescale 1ns/100ps
`default_nettype none
module conv_tx_model (
  input  wire logic       pclk,         // Clock.
  input  wire logic       go,           // Start.
  input  wire logic [2:0] kind,         // Event kind.
  input  wire logic [4:0] arg,          // Argument.
  output logic            busy,         // Running.
  output logic            sysref,       // SYSREF.
  output logic            cdr_locked,   // Lock.
  output logic [3:0]      pcfifo_empty, // Empty.
  output logic [3:0]      pcfifo_full,  // Full.
  output logic            deskew_fail,  // Deskew.
  output logic            sh_strobe,    // Header.
  output logic [1:0]      sh_bits,      // Bits.
  output logic            eomb_strobe,  // Pilot.
  output logic [4:0]      eomb_pilot    // Field.
);
  logic [6:0] t_ff = 7'h00;
  logic [2:0] k_ff = 3'h0;
  logic [4:0] a_ff = 5'h00;
  logic       hot;
  assign busy = t_ff != 7'h00;
  assign hot = t_ff > 7'h24;
  initial begin
    {sysref, pcfifo_empty, pcfifo_full, deskew_fail, sh_strobe, eomb_strobe} = 12'h000;
    {cdr_locked, sh_bits, eomb_pilot} = 8'hFF;
  end
  always @(posedge pclk) begin
    t_ff <= go ? 7'h28 : t_ff - {6'h00, busy};
    k_ff <= go ? kind : k_ff;
    a_ff <= go ? arg : a_ff;
    // Fields outside their strobe mean nothing, so they keep changing rather than hold a stale value.
    sh_bits <= (k_ff == 3'h0 && t_ff == 7'h28) ? a_ff[1:0] : ~sh_bits;
    eomb_pilot <= (k_ff == 3'h1 && t_ff == 7'h28) ? a_ff : ~eomb_pilot;
    sh_strobe <= k_ff == 3'h0 && t_ff == 7'h28;
    eomb_strobe <= k_ff == 3'h1 && t_ff == 7'h28;
    pcfifo_empty <= (k_ff == 3'h2 && hot) ? 4'h1 << a_ff[1:0] : 4'h0;
    pcfifo_full <= (k_ff == 3'h3 && hot) ? 4'h1 << a_ff[1:0] : 4'h0;
    deskew_fail <= k_ff == 3'h4 && t_ff == 7'h28;
    cdr_locked <= !(k_ff == 3'h5 && hot);
    // Edges eleven and then twelve cycles apart never meet the counter's period boundary.
    sysref <= k_ff == 3'h6 && t_ff[6:1] inside {6'h14, 6'h0E, 6'h08};
  end
endmodule
`default_nettype wire

// ==== verif/test_rx_link_error_monitor.sv ====
// Self-checking bench of the receive link error monitor.
// Assumes the APB slave and the converter model share one 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module test_rx_link_error_monitor;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, link_reinit, irq, go, busy, err;
  logic        dll_valid, dll_ready, frame_valid, frame_ready, cmd_valid, cmd_ready, ecc_corrected;
  logic        sysref, cdr_locked, deskew_fail, sh_strobe, eomb_strobe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ex;
  logic [3:0]  pstrb, pcfifo_empty, pcfifo_full;
  logic [1:0]  sh_bits;
  logic [4:0]  eomb_pilot, arg, a;
  logic [7:0]  tx_err_evt;
  logic [2:0]  kind, k;
  logic [5:0]  v;
  int          failures = 0, n_compared = 0, n_reinit = 0, seed = 96;
  rx_link_error_monitor #(.LANES(4)) rx_link_error_monitor_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .sysref(sysref), .dll_valid(dll_valid),
    .dll_ready(dll_ready), .frame_valid(frame_valid), .frame_ready(frame_ready), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cdr_locked(cdr_locked), .pcfifo_empty(pcfifo_empty), .pcfifo_full(pcfifo_full),
    .deskew_fail(deskew_fail), .sh_strobe(sh_strobe), .sh_bits(sh_bits), .eomb_strobe(eomb_strobe),
    .eomb_pilot(eomb_pilot), .ecc_corrected(ecc_corrected), .tx_err_evt(tx_err_evt),
    .link_reinit(link_reinit), .irq(irq));
  conv_tx_model conv_tx_model_inst (.pclk(pclk), .go(go), .kind(kind), .arg(arg), .busy(busy), .sysref(sysref),
    .cdr_locked(cdr_locked), .pcfifo_empty(pcfifo_empty), .pcfifo_full(pcfifo_full),
    .deskew_fail(deskew_fail), .sh_strobe(sh_strobe), .sh_bits(sh_bits), .eomb_strobe(eomb_strobe),
    .eomb_pilot(eomb_pilot));
  function automatic logic [31:0] exp_bit(input logic [2:0] kk, input logic [4:0] aa);
    case (kk)
      3'h0: exp_bit = (aa[1] == aa[0]) ? 32'h00000100 : 32'h0;
      3'h1: exp_bit = (aa != 5'h01) ? 32'h00000200 : 32'h0;
      3'h2: exp_bit = 32'h00000020;
      3'h3: exp_bit = 32'h00000040;
      3'h4: exp_bit = 32'h00000080;
      3'h5: exp_bit = 32'h00000010;
      3'h6: exp_bit = 32'h00000001;
      default: exp_bit = 32'h00010000 << aa[2:0];
    endcase
  endfunction
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #300000;
    failures++;
    end_of_test();
  end
  always @(posedge pclk) begin
    if (link_reinit === 1'b1) begin
      n_reinit++;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, go, kind, arg, tx_err_evt, ecc_corrected} = 0;
    {dll_valid, dll_ready, frame_valid, frame_ready, cmd_valid, cmd_ready} = 6'h00;
    ce = 1'b1;
    pstrb = 4'hF;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h064, 0); chk(rd, 32'h00FF03FF);
    apb(0, 12'h06C, 0); chk(rd & 32'h0000FF01, 32'h00001F01);
    apb(0, 12'h068, 0); chk(rd, 32'h0);
    // A frozen block must drop a stream error and stall a read until its data is loaded.
    ce <= 1'b0;
    dll_valid <= 1'b1;
    @(posedge pclk);
    chk({31'h0, pready}, 32'h0);
    dll_valid <= 1'b0;
    fork
      apb(0, 12'h064, 0);
      begin
        @(posedge pclk);
        ce <= 1'b1;
      end
    join
    chk(rd, 32'h00FF03FF);
    apb(1, 12'h070, 32'hFFFFFFFF); chk({31'h0, err}, 32'h1);
    ecc_corrected <= 1'b1;
    @(posedge pclk);
    ecc_corrected <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(0, 12'h060, 0); chk(rd, 32'h00000400);
    chk({31'h0, irq}, 32'h0);
    for (int p = 0; p < 2; p++) begin
      ex = 32'h400;
      for (int i = 0; i < 20; i++) begin
        v = 6'($random(seed));
        if (p == 0) begin
          v = v & {v[4], 1'b1, v[2], 1'b1, v[0], 1'b1};
        end
        ex = ex | {28'h0, v[1] & ~v[0], v[3] & ~v[2], v[5] & ~v[4], 1'b0};
        {dll_valid, dll_ready, frame_valid, frame_ready, cmd_valid, cmd_ready} <= v;
        @(posedge pclk);
      end
      {dll_valid, dll_ready, frame_valid, frame_ready, cmd_valid, cmd_ready} <= 6'h00;
      @(posedge pclk);
      apb(0, 12'h060, 0); chk(rd, ex);
      apb(1, 12'h060, ex & 32'h0E);
    end
    for (int i = 0; i < 16; i++) begin
      k = i[2:0];
      a = (i == 9) ? 5'h01 : 5'($random(seed));
      if (i == 14) begin
        pstrb <= 4'h1;
        apb(1, 12'h06C, 32'h00000000);
        pstrb <= 4'hF;
        apb(0, 12'h06C, 0);
        chk(rd & 32'h0000FF01, 32'h00001F00);
      end
      ex = exp_bit(k, a);
      if (k == 3'h7) begin
        tx_err_evt <= 8'h01 << a[2:0];
        @(posedge pclk);
        tx_err_evt <= 8'h00;
      end else begin
        kind <= k;
        arg <= a;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (2) @(posedge pclk);
        while (busy === 1'b1) begin
          @(posedge pclk);
        end
      end
      repeat (6) @(posedge pclk);
      apb(0, 12'h060, 0); chk(rd, ex | 32'h400);
      chk({31'h0, irq}, {31'h0, |ex});
      apb(1, i[0] ? 12'h060 : 12'h068, ex);
      apb(0, 12'h060, 0); chk(rd, 32'h400);
      chk({31'h0, irq}, 32'h0);
    end
    chk(32'(n_reinit), 32'h1);
    apb(1, 12'h064, 32'h00FF07FF); chk({31'h0, irq}, 32'h1);
    apb(0, 12'h064, 0); chk(rd, 32'h00FF07FF);
    apb(1, 12'h060, 32'h400); chk({31'h0, irq}, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
